/* File: src/sio_pkg.sv */
// Shared constants, register map and state types of the serial error-handling unit
package sio_pkg;

	// Bus geometry
	localparam int          SIO_ADDR_W     = 8;
	localparam int          SIO_DATA_W     = 32;
	localparam logic [1:0]  SIO_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  SIO_RESP_SLVERR = 2'h2;

	// Register byte offsets
	localparam logic [7:0]  SIO_OFF_CTRL      = 8'h00; // serial_control_reg_one
	localparam logic [7:0]  SIO_OFF_STATUS    = 8'h04; // serial_status_reg
	localparam logic [7:0]  SIO_OFF_TXBUF     = 8'h08; // tx_buffer
	localparam logic [7:0]  SIO_OFF_RXBUF     = 8'h0c; // rx_buffer
	localparam logic [7:0]  SIO_OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0]  SIO_OFF_IRQ_MASK  = 8'h14;

	// Control register fields
	localparam int          SIO_CTRL_START   = 0;
	localparam int          SIO_CTRL_INHIBIT = 1;
	localparam int          SIO_CTRL_LSB     = 2;

	// Status register fields
	localparam int          SIO_ST_TXEMPTY   = 0;
	localparam int          SIO_ST_RXFULL    = 1;
	localparam int          SIO_ST_TX_ERROR_FLAG     = 2;
	localparam int          SIO_ST_RX_ERROR_FLAG     = 3;
	localparam int          SIO_ST_INPROG    = 4;
	localparam int          SIO_ST_SHACT     = 5;

	// Interrupt status and mask fields
	localparam int          SIO_IRQ_W        = 3;
	localparam int          SIO_IRQ_BYTE     = 0;
	localparam int          SIO_IRQ_TX_ERROR_FLAG    = 1;
	localparam int          SIO_IRQ_RX_ERROR_FLAG    = 2;

	// Frame geometry
	localparam int          SIO_BITS         = 8;
	localparam logic [3:0]  SIO_LAST_BIT     = 4'h7;

	// Reset values
	localparam logic        SIO_TXEMPTY_RST  = 1'b1;
	localparam logic        SIO_SDO_IDLE     = 1'b1;

	typedef enum logic [1:0] {
		SIO_IDLE  = 2'b00,
		SIO_SHIFT = 2'b01,
		SIO_GAP   = 2'b10
	} sio_phase_e;

	typedef struct packed {
		logic txEmpty;
		logic rxFull;
		logic txError;
		logic rxError;
		logic inProgress;
		logic shiftActive;
	} sio_flags_s;

	typedef struct packed {
		sio_phase_e            phase;
		logic                  start;
		logic                  lsbFirst;
		logic [SIO_BITS-1:0]   txBuffer;
		logic [SIO_BITS-1:0]   rxBuffer;
		logic [SIO_BITS-1:0]   shiftReg;
		logic [3:0]            bitCnt;
		sio_flags_s            flags;
		logic                  rxErrRead;
		logic                  sdo;
		logic [SIO_IRQ_W-1:0]  irqStatus;
		logic [SIO_IRQ_W-1:0]  irqMask;
		logic                  haveAw;
		logic [SIO_ADDR_W-1:0] awAddr;
		logic                  haveW;
		logic [SIO_DATA_W-1:0] wData;
		logic                  wStrb0;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [SIO_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
	} sio_state_s;

	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
		logic       sckPrev;
	} sio_sync_s;

endpackage : sio_pkg

/* File: src/sio_sync.sv */
// Two-stage synchroniser for the serial pins with serial clock edge detection
`timescale 1ns/1ps
module sio_sync
	import sio_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Raw pins
	input  wire logic sckPin,
	input  wire logic sdiPin,
	// Synchronised outputs
	output logic      sdiSync,
	output logic      sckRise,
	output logic      sckFall
);

	sio_sync_s st;
	sio_sync_s next_st;

	// Stage one feeds only stage two; edges are judged on stage two
	always_comb begin
		next_st         = st;
		next_st.stage1  = {sckPin, sdiPin};
		next_st.stage2  = st.stage1;
		next_st.sckPrev = st.stage2[1];
	end

	// Pins idle high, so the pipeline resets high to avoid a false edge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	// Edge pulses from synchronised levels
	assign sdiSync = st.stage2[0];
	assign sckRise = st.stage2[1] & ~st.sckPrev; // RL14
	assign sckFall = ~st.stage2[1] & st.sckPrev; // RL14

endmodule : sio_sync

/* File: src/sio_txrx_err.sv */
// Serial transmit/receive unit with error detection, recovery and AXI4-Lite registers
//
// Contract
// RL1 - Shift start with empty transmit buffer flags error
// RL2 - Error flag at shift start; interrupt after byte
// RL3 - First shift with nothing written flags error
// RL4 - Data output held high during transmit error
// RL5 - Software reads receive buffer, then writes inhibit
// RL6 - Inhibit halts transfer and clears all state; interrupt status, mask and shift register are kept; code sets lsbFirst from the written data
// RL7 - Receive error discards new data, keeps contents
// RL8 - Byte done while receive full flags error
// RL9 - Second read returns shift register at error
// RL10 - Receive full clears after receive error clears
// RL11 - Stop after byte when start cleared
// RL12 - Transmit empty set at rising edge after load; the code skips this while the transmit error flag is set
// RL13 - Byte done: copy, set full, interrupt together
// RL14 - External serial clock synchronised before use
`timescale 1ns/1ps
module sio_txrx_err
	import sio_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// AXI4-Lite write address
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [SIO_ADDR_W-1:0] awaddr,
	// AXI4-Lite write data
	input  wire logic                  wvalid,
	output logic                       wready,
	input  wire logic [SIO_DATA_W-1:0] wdata,
	input  wire logic [3:0]            wstrb,
	// AXI4-Lite write response
	output logic                       bvalid,
	input  wire logic                  bready,
	output logic [1:0]                 bresp,
	// AXI4-Lite read address
	input  wire logic                  arvalid,
	output logic                       arready,
	input  wire logic [SIO_ADDR_W-1:0] araddr,
	// AXI4-Lite read data
	output logic                       rvalid,
	input  wire logic                  rready,
	output logic [SIO_DATA_W-1:0]      rdata,
	output logic [1:0]                 rresp,
	// Serial pins
	input  wire logic                  sckPin,
	input  wire logic                  sdiPin,
	output logic                       sdoPin,
	// Interrupt
	output logic                       serialInterrupt
);

	// State register and its next value
	sio_state_s          st;
	sio_state_s          next_st;

	// Synchronised data level and serial clock edges
	logic                sdiSync;
	logic                sckRise;
	logic                sckFall;

	// Strobes that live for one cycle only
	logic                doWrite;
	logic                doInhibit;
	logic                doLoad;
	logic                byteDone;

	// Access decode and the shifted word
	logic                wrOk;
	logic [SIO_BITS-1:0] inShift;
	logic [SIO_DATA_W-1:0] rdVal;
	logic                rdOk;

	// Pin synchronisers and edge detection
	sio_sync u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.sckPin  (sckPin),
		.sdiPin  (sdiPin),
		.sdiSync (sdiSync),
		.sckRise (sckRise),
		.sckFall (sckFall)
	);

	// Bus handshakes; one write and one read are held at a time
	assign awready = ~st.haveAw & ~st.bvalid;
	assign wready  = ~st.haveW & ~st.bvalid;
	assign arready = ~st.rvalid;

	// Software first, hardware after so a hardware set wins; inhibit last so it overrides both
	always_comb begin
		next_st   = st;
		doWrite   = st.haveAw & st.haveW & ~st.bvalid;
		doInhibit = 1'b0;
		doLoad    = 1'b0;
		byteDone  = 1'b0;
		wrOk      = 1'b0;
		rdOk      = 1'b1;
		rdVal     = '0;

		// New bit enters at the end opposite to the one being sent
		if (st.lsbFirst) begin
			inShift = {sdiSync, st.shiftReg[SIO_BITS-1:1]};
		end else begin
			inShift = {st.shiftReg[SIO_BITS-2:0], sdiSync};
		end

		// Write address and data may arrive in either order
		if (awvalid && awready) begin
			next_st.haveAw = 1'b1;
			next_st.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			next_st.haveW  = 1'b1;
			next_st.wData  = wdata;
			next_st.wStrb0 = wstrb[0];
		end

		// Answers leave once the master has taken them
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end

		// Register writes; all fields live in byte lane zero
		if (doWrite) begin
			next_st.haveAw = 1'b0;
			next_st.haveW  = 1'b0;
			next_st.bvalid = 1'b1;
			case (st.awAddr)
				SIO_OFF_CTRL: begin
					wrOk = 1'b1;
					if (st.wStrb0) begin
						next_st.start    = st.wData[SIO_CTRL_START];
						next_st.lsbFirst = st.wData[SIO_CTRL_LSB];
						doInhibit        = st.wData[SIO_CTRL_INHIBIT];
					end
				end
				SIO_OFF_TXBUF: begin
					// Loading clears empty; a hardware set in the same cycle still wins
					wrOk = 1'b1;
					if (st.wStrb0) begin
						next_st.txBuffer      = st.wData[SIO_BITS-1:0];
						next_st.flags.txEmpty = 1'b0;
					end
				end
				SIO_OFF_IRQ_STAT: begin
					wrOk = 1'b1;
					if (st.wStrb0) begin
						next_st.irqStatus = st.irqStatus & ~st.wData[SIO_IRQ_W-1:0];
					end
				end
				SIO_OFF_IRQ_MASK: begin
					wrOk = 1'b1;
					if (st.wStrb0) begin
						next_st.irqMask = st.wData[SIO_IRQ_W-1:0];
					end
				end
				default: begin
					wrOk = 1'b0;
				end
			endcase
			// Unmapped and read-only offsets answer with a slave error
			next_st.bresp = wrOk ? SIO_RESP_OKAY : SIO_RESP_SLVERR;
		end

		// Register reads; the receive buffer read carries the recovery sequence
		if (arvalid && arready) begin
			case (araddr)
				SIO_OFF_CTRL: begin
					rdVal[SIO_CTRL_START] = st.start;
					rdVal[SIO_CTRL_LSB]   = st.lsbFirst;
				end
				SIO_OFF_STATUS: begin
					rdVal[SIO_ST_TXEMPTY] = st.flags.txEmpty;
					rdVal[SIO_ST_RXFULL]  = st.flags.rxFull;
					rdVal[SIO_ST_TX_ERROR_FLAG]   = st.flags.txError;
					rdVal[SIO_ST_RX_ERROR_FLAG]   = st.flags.rxError;
					rdVal[SIO_ST_INPROG]  = st.flags.inProgress;
					rdVal[SIO_ST_SHACT]   = st.flags.shiftActive;
				end
				SIO_OFF_TXBUF: begin
					rdVal[SIO_BITS-1:0] = st.txBuffer;
				end
				SIO_OFF_RXBUF: begin
					// After an overrun the first read gives the older byte, the second the captured one
					if (st.flags.rxError && !st.rxErrRead) begin
						rdVal[SIO_BITS-1:0] = st.rxBuffer; // RL9
						next_st.rxErrRead   = 1'b1;
					end else if (st.flags.rxError) begin
						rdVal[SIO_BITS-1:0]   = st.shiftReg; // RL9
						next_st.rxErrRead     = 1'b0;
						next_st.flags.rxError = 1'b0;
						next_st.flags.rxFull  = 1'b0; // RL10
					end else begin
						rdVal[SIO_BITS-1:0]  = st.rxBuffer;
						next_st.flags.rxFull = 1'b0;
					end
				end
				SIO_OFF_IRQ_STAT: begin
					rdVal[SIO_IRQ_W-1:0] = st.irqStatus;
				end
				SIO_OFF_IRQ_MASK: begin
					rdVal[SIO_IRQ_W-1:0] = st.irqMask;
				end
				default: begin
					rdOk = 1'b0;
				end
			endcase
			// Reads answer in the next cycle whatever the address
			next_st.rvalid = 1'b1;
			next_st.rdata  = rdVal;
			next_st.rresp  = rdOk ? SIO_RESP_OKAY : SIO_RESP_SLVERR;
		end

		// Link sequencing on synchronised serial clock edges
		case (st.phase)
			SIO_IDLE: begin
				// A frame opens only on a falling edge while start is set
				doLoad = sckFall & st.start;
			end
			SIO_SHIFT: begin
				// Rising edge samples the input, falling edge launches the next bit
				if (sckRise) begin
					if (!st.flags.rxError) begin
						next_st.shiftReg = inShift; // RL7
					end
					if (st.bitCnt == 4'h0 && !st.flags.txError) begin
						next_st.flags.txEmpty = 1'b1; // RL12
					end
					next_st.bitCnt = 4'(st.bitCnt + 4'h1);
					byteDone       = (st.bitCnt == SIO_LAST_BIT);
				end else if (sckFall && st.bitCnt != 4'h0) begin
					if (st.flags.txError) begin
						next_st.sdo = SIO_SDO_IDLE; // RL4
					end else if (st.lsbFirst) begin
						next_st.sdo = st.shiftReg[0];
					end else begin
						next_st.sdo = st.shiftReg[SIO_BITS-1];
					end
				end
			end
			SIO_GAP: begin
				// Between bytes: stop once start is cleared, else wait for a falling edge
				if (!st.start) begin
					next_st.phase            = SIO_IDLE; // RL11
					next_st.flags.inProgress = 1'b0;
				end else begin
					doLoad = sckFall;
				end
			end
			default: begin
				next_st.phase = SIO_IDLE;
			end
		endcase

		// Shift start: move the buffer in, or flag an underrun at once
		if (doLoad) begin
			next_st.phase             = SIO_SHIFT;
			next_st.bitCnt            = 4'h0;
			next_st.flags.inProgress  = 1'b1;
			next_st.flags.shiftActive = 1'b1;
			if (st.flags.txEmpty) begin
				next_st.flags.txError = 1'b1; // RL1 RL3 RL2
			end
			if (!st.flags.rxError) begin
				next_st.shiftReg = st.txBuffer; // RL7
			end
			// An underrun shows a high line rather than stale buffer contents
			if (st.flags.txEmpty || st.flags.txError) begin
				next_st.sdo = SIO_SDO_IDLE; // RL4
			end else if (st.lsbFirst) begin
				next_st.sdo = st.txBuffer[0];
			end else begin
				next_st.sdo = st.txBuffer[SIO_BITS-1];
			end
		end

		// Byte complete: deliver it, or declare an overrun and keep both stores
		if (byteDone) begin
			next_st.flags.shiftActive = 1'b0;
			next_st.sdo               = SIO_SDO_IDLE;
			next_st.phase             = st.start ? SIO_GAP : SIO_IDLE; // RL11
			next_st.flags.inProgress  = st.start;
			// A buffer read in this very cycle has freed the buffer, so that byte is no overrun
			if (st.flags.rxError) begin
				next_st.shiftReg = st.shiftReg; // RL7
			end else if (next_st.flags.rxFull) begin
				next_st.flags.rxError               = 1'b1; // RL8
				next_st.irqStatus[SIO_IRQ_RX_ERROR_FLAG]    = 1'b1; // RL8
				next_st.irqStatus[SIO_IRQ_BYTE]     = 1'b1;
			end else begin
				next_st.rxBuffer                    = inShift; // RL13
				next_st.flags.rxFull                = 1'b1; // RL13
				next_st.irqStatus[SIO_IRQ_BYTE]     = 1'b1; // RL13
			end
			// The underrun interrupt waits until the whole byte is in
			if (st.flags.txError) begin
				next_st.irqStatus[SIO_IRQ_TX_ERROR_FLAG] = 1'b1; // RL2
			end
		end

		// Forced stop: start bit, status, both buffers and the sequencer return to reset
		if (doInhibit) begin
			// Interrupt status and mask are kept so software still sees why it stopped
			next_st.start             = 1'b0; // RL6
			next_st.phase             = SIO_IDLE; // RL6
			next_st.bitCnt            = 4'h0;
			next_st.flags             = '0; // RL6
			next_st.flags.txEmpty     = SIO_TXEMPTY_RST;
			next_st.rxBuffer          = '0; // RL6
			next_st.txBuffer          = '0; // RL6
			next_st.rxErrRead         = 1'b0;
			next_st.sdo               = SIO_SDO_IDLE;
		end
	end

	// Single state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st               <= '0;
			st.flags.txEmpty <= SIO_TXEMPTY_RST;
			st.sdo           <= SIO_SDO_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs; data outputs straight from flip-flops
	assign bvalid          = st.bvalid;
	assign bresp           = st.bresp;
	assign rvalid          = st.rvalid;
	assign rdata           = st.rdata;
	assign rresp           = st.rresp;

	// Link output and interrupt; the interrupt is a plain level of registered bits
	assign sdoPin          = st.sdo;
	assign serialInterrupt = |(st.irqStatus & st.irqMask);

endmodule : sio_txrx_err

/* File: testbench/sio_chk.sv */
// Port-level assertions of the serial error-handling unit
`timescale 1ns/1ps
module sio_chk
	import sio_pkg::*;
(
	// Clock and reset
	input wire logic                  clk_sys,
	input wire logic                  resetn,
	// Register bus
	input wire logic                  awvalid,
	input wire logic                  awready,
	input wire logic                  wvalid,
	input wire logic                  wready,
	input wire logic                  bvalid,
	input wire logic                  bready,
	input wire logic [1:0]            bresp,
	input wire logic                  arvalid,
	input wire logic                  arready,
	input wire logic                  rvalid,
	input wire logic                  rready,
	input wire logic [SIO_DATA_W-1:0] rdata,
	// Serial pins and interrupt
	input wire logic                  sckPin,
	input wire logic                  sdoPin,
	input wire logic                  serialInterrupt
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// Bus answers hold until taken
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
	wr_refuse_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while answer pending");
	rd_refuse_a: assert property (rvalid |-> !arready) else $error("read taken while answer pending");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("no write answer");
	rd_answer_a: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
	// Bits launch only after a synchronised falling serial clock
	sdo_launch_a: assert property ($fell(sdoPin) |-> !$past(sckPin, 2)) else $error("data out moved early");
	// Interrupt rises at byte end or on a mask write, falls only on a write
	irq_rise_a: assert property ($rose(serialInterrupt) |-> $past(sckPin, 2) || bvalid) else $error("stray interrupt");
	irq_fall_a: assert property ($fell(serialInterrupt) |-> bvalid) else $error("interrupt lost");

	cover property ($rose(serialInterrupt));
	cover property ($fell(sdoPin));
	cover property (rvalid && !rready);
	cover property (bvalid && bready && bresp == SIO_RESP_SLVERR);
endmodule : sio_chk

bind sio_txrx_err sio_chk chk_u (.clk_sys, .resetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .sckPin, .sdoPin, .serialInterrupt);

/* File: testbench/sio_peer.sv */
// External-clock serial peer: clocks whole bytes in and out
`timescale 1ns/1ps
module sio_peer (
	// Serial pins
	output logic     sckPin,
	output logic     sdiPin,
	input wire logic sdoPin
);
	initial begin
		sckPin = 1'b1;
		sdiPin = 1'b0;
	end

	// Eight clock pairs of 800 ns; clock idles high between bytes
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#37;
		for (int i = 7; i >= 0; i--) begin
			sckPin = 1'b0;
			sdiPin = tx[i];
			#400;
			rx[i] = sdoPin;
			sckPin = 1'b1;
			#400;
		end
		sdiPin = ~sdiPin; // Released line must not keep the last bit
	endtask : xfer
endmodule : sio_peer

/* File: testbench/tb.sv */
// Self-checking bench of the serial error-handling unit
`timescale 1ns/1ps
module tb
	import sio_pkg::*;
;
	logic        clk_sys = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, so;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, sckPin, sdiPin, sdoPin, serialInterrupt;
	int          errors = 0, n_checks = 0;

	sio_txrx_err dut_u (.clk_sys, .resetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.sckPin, .sdiPin, .sdoPin, .serialInterrupt);
	sio_peer peer_u (.sckPin, .sdiPin, .sdoPin);

	always #50 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// Bus write: both channels offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d;
		// Ready is raised only once the answer shows, so the slave must hold it
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		chk(32'(bresp), 32'(er));
		bready <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		arvalid <= 1'b1; araddr <= a;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
		rready <= 1'b0;
	endtask : rdc

	task automatic tally_and_finish();
		if (errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish

	// Watchdog: the whole sequence needs well under a tenth of this
	initial begin
		#2000000;
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		rdc(SIO_OFF_STATUS, 32'h01, SIO_RESP_OKAY);
		rdc(8'h18, 32'h0, SIO_RESP_SLVERR);
		wr(SIO_OFF_STATUS, 32'h3f, SIO_RESP_SLVERR);
		wr(SIO_OFF_IRQ_MASK, 32'h7, SIO_RESP_OKAY);
		rdc(SIO_OFF_IRQ_MASK, 32'h7, SIO_RESP_OKAY);
		wr(SIO_OFF_TXBUF, 32'ha5, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h00, SIO_RESP_OKAY);
		wr(SIO_OFF_CTRL, 32'h1, SIO_RESP_OKAY);
		// Clean byte, then a byte with nothing loaded and nothing read
		peer_u.xfer(8'h3c, so);
		chk(32'(so), 32'ha5);
		rdc(SIO_OFF_STATUS, 32'h13, SIO_RESP_OKAY);
		chk(32'(serialInterrupt), 32'h1);
		wr(SIO_OFF_IRQ_MASK, 32'h0, SIO_RESP_OKAY);
		chk(32'(serialInterrupt), 32'h0);
		wr(SIO_OFF_IRQ_MASK, 32'h7, SIO_RESP_OKAY);
		peer_u.xfer(8'h5a, so);
		chk(32'(so), 32'hff);
		rdc(SIO_OFF_STATUS, 32'h1f, SIO_RESP_OKAY);
		rdc(SIO_OFF_IRQ_STAT, 32'h7, SIO_RESP_OKAY);
		peer_u.xfer(8'h99, so);
		chk(32'(so), 32'hff);
		// Receive recovery: stop, then two reads
		wr(SIO_OFF_CTRL, 32'h0, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h0f, SIO_RESP_OKAY);
		rdc(SIO_OFF_RXBUF, 32'h3c, SIO_RESP_OKAY);
		rdc(SIO_OFF_RXBUF, 32'h5a, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h05, SIO_RESP_OKAY);
		wr(SIO_OFF_CTRL, 32'h2, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h01, SIO_RESP_OKAY);
		rdc(SIO_OFF_RXBUF, 32'h0, SIO_RESP_OKAY);
		rdc(SIO_OFF_TXBUF, 32'h0, SIO_RESP_OKAY);
		// A write with byte lane zero switched off must change nothing
		wstrb <= 4'he;
		wr(SIO_OFF_TXBUF, 32'h55, SIO_RESP_OKAY);
		wstrb <= 4'hf;
		rdc(SIO_OFF_TXBUF, 32'h0, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h01, SIO_RESP_OKAY);
		rdc(SIO_OFF_CTRL, 32'h0, SIO_RESP_OKAY);
		wr(SIO_OFF_IRQ_STAT, 32'h7, SIO_RESP_OKAY);
		chk(32'(serialInterrupt), 32'h0);
		// First shift after start with nothing written, low bit first
		wr(SIO_OFF_CTRL, 32'h5, SIO_RESP_OKAY);
		peer_u.xfer(8'hc1, so);
		chk(32'(so), 32'hff);
		rdc(SIO_OFF_STATUS, 32'h17, SIO_RESP_OKAY);
		rdc(SIO_OFF_RXBUF, 32'h83, SIO_RESP_OKAY);
		rdc(SIO_OFF_IRQ_STAT, 32'h3, SIO_RESP_OKAY);
		wr(SIO_OFF_CTRL, 32'h2, SIO_RESP_OKAY);
		rdc(SIO_OFF_STATUS, 32'h01, SIO_RESP_OKAY);
		tally_and_finish();
	end
endmodule : tb
